// file: pkg/fsf_consts.svh
// constants for the flash driver status-flag and limit-select block
// assumes inclusion by bare name from package and design files
`ifndef FSF_CONSTS_SVH
`define FSF_CONSTS_SVH
// register offsets
`define FSF_OFS_MASK_LIMIT 8'h03
`define FSF_OFS_LOW_INPUT 8'h04
`define FSF_OFS_STATUS 8'h08
`define FSF_OFS_STATUS2 8'h09
// field positions
`define FSF_BIT_TX_EN 7
`define FSF_BIT_LOW_EN 6
`define FSF_BIT_ILIM_HI 1
`define FSF_BIT_ILIM_LO 0
`define FSF_BIT_THR_HI 2
`define FSF_BIT_THR_LO 0
`define FSF_BIT_INPUT_LOW 1
`define FSF_BIT_TX_FLAG 3
// reset values; limit field 2'b01 selects 2.6 A
`define FSF_RST_MASK_LIMIT 8'h01
`define FSF_RST_LOW_INPUT 8'h00
`define FSF_RST_STATUS 8'h00
`endif

// file: pkg/fsf_pkg.sv
// types for the flash driver status-flag and limit-select block
// assumes fsf_consts.svh on the include path
`include "fsf_consts.svh"
package fsf_pkg;
	// peak current limit choices
	typedef enum logic [1:0]
	{
		FSF_ILIM_2A3 = 2'h0,
		FSF_ILIM_2A6 = 2'h1,
		FSF_ILIM_2A9 = 2'h2,
		FSF_ILIM_3A3 = 2'h3
	} fsf_ilim_e;
	// register access request
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fsf_req_s;
	// synchronised pin levels
	typedef struct packed
	{
		logic tx_mask;
		logic input_low;
		logic ilim_hit;
	} fsf_pins_s;
endpackage : fsf_pkg

// file: src/fsf_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous levels
`timescale 1ns/100ps
module fsf_sync
#(
	parameter int W = 3
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	// first stage only feeds the second
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : fsf_sync

// file: src/fsf_status_flags.sv
// status flags, low-input capture and peak current limit of a flash boost driver
// assumes a register port from the serial interface logic on sys_clk
`timescale 1ns/100ps
`include "fsf_consts.svh"
module fsf_status_flags
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire fsf_pkg::fsf_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire logic flash_start_req,
	input wire logic flash_active,
	input wire logic tx_mask_pin,
	input wire logic input_below_threshold,
	input wire logic ilim_sense_hit,
	input wire logic charge_phase_req,
	output logic [2:0] low_input_threshold_sel,
	output fsf_pkg::fsf_ilim_e ilim_sel,
	output logic boost_low_side_switch,
	output logic input_low_flag,
	output logic transmit_mask_flag
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// pins reach the logic two edges after they move
	fsf_pkg::fsf_pins_s pins;
	fsf_sync #(.W(3)) fsf_sync_inst
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({tx_mask_pin, input_below_threshold, ilim_sense_hit}),
		.sync_out(pins)
	);

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	// reset images, sliced below for the mirrored outputs
	localparam logic [7:0] RST_MASK_LIMIT = `FSF_RST_MASK_LIMIT;
	localparam logic [7:0] RST_LOW_INPUT = `FSF_RST_LOW_INPUT;
	localparam logic [7:0] RST_STATUS = `FSF_RST_STATUS;
	logic [7:0] mask_and_limit_control;
	logic [7:0] low_input_control;
	logic [7:0] fault_and_flag_status;
	logic [7:0] next_mask_and_limit_control;
	logic [7:0] next_low_input_control;
	logic [7:0] next_fault_and_flag_status;
	logic [7:0] next_reg_rdata;
	logic next_switch;
	logic transmit_mask_enable;
	logic low_input_detect_enable;
	logic status_read;
	logic write_mask_limit;
	logic write_low_input;
	logic input_low_set;
	logic tx_mask_set;
	fsf_pkg::fsf_ilim_e next_ilim_sel;
	logic [2:0] next_low_input_threshold_sel;
	logic next_input_low_flag;
	logic next_transmit_mask_flag;

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	// enables straight from the control bits
	assign transmit_mask_enable = mask_and_limit_control[`FSF_BIT_TX_EN];
	assign low_input_detect_enable = low_input_control[`FSF_BIT_LOW_EN];
	// one-cycle write strobes per control register
	assign write_mask_limit = reg_req.wr && (reg_req.addr == `FSF_OFS_MASK_LIMIT);
	assign write_low_input = reg_req.wr && (reg_req.addr == `FSF_OFS_LOW_INPUT);
	// either status address clears the recorded bits
	assign status_read = reg_req.rd && (reg_req.addr == `FSF_OFS_STATUS
		|| reg_req.addr == `FSF_OFS_STATUS2);
	// capture only at a start request outside a flash
	assign input_low_set = low_input_detect_enable && flash_start_req && !flash_active
		&& pins.input_low;
	assign tx_mask_set = transmit_mask_enable && pins.tx_mask;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	// host writes replace the whole byte
	always_comb
	begin
		next_mask_and_limit_control = mask_and_limit_control;
		next_low_input_control = low_input_control;
		if (write_mask_limit)
			next_mask_and_limit_control = reg_req.wdata;
		if (write_low_input)
			next_low_input_control = reg_req.wdata;
	end

	// limit field powers up at the second-lowest setting
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mask_and_limit_control <= `FSF_RST_MASK_LIMIT;
			low_input_control <= `FSF_RST_LOW_INPUT;
		end
		else
		begin
			mask_and_limit_control <= next_mask_and_limit_control;
			low_input_control <= next_low_input_control;
		end
	end

	// ------------------------------------------------------------
	// status register
	// ------------------------------------------------------------
	// read clears recorded bits; a set in the same cycle wins
	// other fault bits of this byte belong to logic outside this block
	always_comb
	begin
		next_fault_and_flag_status = fault_and_flag_status;
		if (status_read)
			next_fault_and_flag_status = 8'h00;
		if (input_low_set)
			next_fault_and_flag_status[`FSF_BIT_INPUT_LOW] = 1'b1;
		if (tx_mask_set)
			next_fault_and_flag_status[`FSF_BIT_TX_FLAG] = 1'b1;
	end

	// flags only report: no path to standby, output stop or state reset
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			fault_and_flag_status <= `FSF_RST_STATUS;
		else
			fault_and_flag_status <= next_fault_and_flag_status;
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	// read data stands until the next read; unmapped addresses give zero
	always_comb
	begin
		next_reg_rdata = reg_rdata;
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				`FSF_OFS_MASK_LIMIT: next_reg_rdata = mask_and_limit_control;
				`FSF_OFS_LOW_INPUT: next_reg_rdata = low_input_control;
				`FSF_OFS_STATUS: next_reg_rdata = fault_and_flag_status;
				default: next_reg_rdata = 8'h00;
			endcase
		end
	end

	// registered read data port
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_reg_rdata;
	end

	// ------------------------------------------------------------
	// mirrored outputs
	// ------------------------------------------------------------
	// outputs follow the register contents of the same edge
	always_comb
	begin
		next_ilim_sel = fsf_pkg::fsf_ilim_e'(
			next_mask_and_limit_control[`FSF_BIT_ILIM_HI:`FSF_BIT_ILIM_LO]);
		next_low_input_threshold_sel =
			next_low_input_control[`FSF_BIT_THR_HI:`FSF_BIT_THR_LO];
		next_input_low_flag = next_fault_and_flag_status[`FSF_BIT_INPUT_LOW];
		next_transmit_mask_flag = next_fault_and_flag_status[`FSF_BIT_TX_FLAG];
	end

	// every output from a flop; reset images match the registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ilim_sel <= fsf_pkg::fsf_ilim_e'(RST_MASK_LIMIT[`FSF_BIT_ILIM_HI:`FSF_BIT_ILIM_LO]);
			low_input_threshold_sel <= RST_LOW_INPUT[`FSF_BIT_THR_HI:`FSF_BIT_THR_LO];
			input_low_flag <= RST_STATUS[`FSF_BIT_INPUT_LOW];
			transmit_mask_flag <= RST_STATUS[`FSF_BIT_TX_FLAG];
		end
		else
		begin
			ilim_sel <= next_ilim_sel;
			low_input_threshold_sel <= next_low_input_threshold_sel;
			input_low_flag <= next_input_low_flag;
			transmit_mask_flag <= next_transmit_mask_flag;
		end
	end

	// ------------------------------------------------------------
	// peak current limit
	// ------------------------------------------------------------
	// switch on for charge request during a flash unless limit reached
	// the sense lags two edges, so two more charge cycles may pass
	always_comb
	begin
		next_switch = charge_phase_req && flash_active && !pins.ilim_hit;
	end

	// limit only gates the switch; it never touches status or enables
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			boost_low_side_switch <= 1'b0;
		else
			boost_low_side_switch <= next_switch;
	end
endmodule : fsf_status_flags

// file: sim/fsf_status_flags_props.sv
// checker for the status-flag block ports
// assumes a bind onto fsf_status_flags
`timescale 1ns/100ps
module fsf_status_flags_props
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire fsf_pkg::fsf_req_s reg_req,
	input wire logic flash_start_req,
	input wire logic flash_active,
	input wire logic tx_mask_pin,
	input wire logic input_below_threshold,
	input wire logic ilim_sense_hit,
	input wire logic charge_phase_req,
	input wire fsf_pkg::fsf_ilim_e ilim_sel,
	input wire logic boost_low_side_switch,
	input wire logic input_low_flag,
	input wire logic transmit_mask_flag
);
	// one clock domain, reset disables all
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	sw_stop_a: assert property (ilim_sense_hit [*4] |=> !boost_low_side_switch)
		else $error("switch on at limit");
	sw_run_a: assert property ((charge_phase_req && flash_active && !ilim_sense_hit) [*4]
		|=> boost_low_side_switch) else $error("switch off");
	tx_set_a: assert property ($rose(transmit_mask_flag) |-> $past(tx_mask_pin, 3))
		else $error("mask flag");
	low_set_a: assert property ($rose(input_low_flag) |-> $past(flash_start_req)
		&& !$past(flash_active) && $past(input_below_threshold, 3)) else $error("low flag");
	low_clr_a: assert property ($fell(input_low_flag) |-> $past(reg_req.rd)
		&& $past(reg_req.addr[7:1]) == 7'h04) else $error("low clear");
	tx_clr_a: assert property ($fell(transmit_mask_flag) |-> $past(reg_req.rd)
		&& $past(reg_req.addr[7:1]) == 7'h04) else $error("mask clear");
	lim_dflt_a: assert property (!$past(rst_n) |-> ilim_sel == fsf_pkg::FSF_ILIM_2A6)
		else $error("limit default");
	lim_wr_a: assert property (ilim_sel != $past(ilim_sel) |-> $past(reg_req.wr)
		&& $past(reg_req.addr) == 8'h03 && ilim_sel == $past(reg_req.wdata[1:0]))
		else $error("limit write");
	cover property ($rose(input_low_flag));
	cover property ($rose(transmit_mask_flag));
	cover property ($fell(boost_low_side_switch));
endmodule : fsf_status_flags_props

bind fsf_status_flags fsf_status_flags_props fsf_status_flags_props_inst
(
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.reg_req(reg_req),
	.flash_start_req(flash_start_req),
	.flash_active(flash_active),
	.tx_mask_pin(tx_mask_pin),
	.input_below_threshold(input_below_threshold),
	.ilim_sense_hit(ilim_sense_hit),
	.charge_phase_req(charge_phase_req),
	.ilim_sel(ilim_sel),
	.boost_low_side_switch(boost_low_side_switch),
	.input_low_flag(input_low_flag),
	.transmit_mask_flag(transmit_mask_flag)
);

// file: sim/fsf_pin_model.sv
// pin model of the boost stage and radio around the block
// assumes bench-set levels; pins lag them like async inputs
`timescale 1ns/100ps
module fsf_pin_model
(
	input wire logic tx_lvl,
	input wire logic low_lvl,
	input wire logic hit_lvl,
	output logic tx_mask_pin,
	output logic input_below_threshold,
	output logic ilim_sense_hit
);
	// pins settle a few ns after the edge
	assign #3 tx_mask_pin = tx_lvl;
	assign #3 input_below_threshold = low_lvl;
	assign #3 ilim_sense_hit = hit_lvl;
endmodule : fsf_pin_model

// file: sim/fsf_status_flags_tb.sv
// bench for the status-flag block
// assumes the pin model and the bound checker
`timescale 1ns/100ps
module fsf_status_flags_tb;
	logic sys_clk = 1'b0, rst_n = 1'b0, flash_start_req = 1'b0, flash_active = 1'b0;
	logic charge_phase_req = 1'b0, tx_lvl = 1'b0, low_lvl = 1'b0, hit_lvl = 1'b0;
	logic tx_mask_pin, input_below_threshold, ilim_sense_hit, boost_low_side_switch;
	logic input_low_flag, transmit_mask_flag;
	logic [7:0] reg_rdata;
	logic [2:0] low_input_threshold_sel;
	fsf_pkg::fsf_ilim_e ilim_sel;
	fsf_pkg::fsf_req_s reg_req = '0;
	int errors = 0, compares = 0, cycles = 0;
	fsf_status_flags fsf_status_flags_inst
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.flash_start_req(flash_start_req),
		.flash_active(flash_active),
		.tx_mask_pin(tx_mask_pin),
		.input_below_threshold(input_below_threshold),
		.ilim_sense_hit(ilim_sense_hit),
		.charge_phase_req(charge_phase_req),
		.low_input_threshold_sel(low_input_threshold_sel),
		.ilim_sel(ilim_sel),
		.boost_low_side_switch(boost_low_side_switch),
		.input_low_flag(input_low_flag),
		.transmit_mask_flag(transmit_mask_flag)
	);
	fsf_pin_model fsf_pin_model_inst
	(
		.tx_lvl(tx_lvl),
		.low_lvl(low_lvl),
		.hit_lvl(hit_lvl),
		.tx_mask_pin(tx_mask_pin),
		.input_below_threshold(input_below_threshold),
		.ilim_sense_hit(ilim_sense_hit)
	);
	// clock and hang guard
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk);
		reg_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk);
		reg_req.rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	task automatic report_and_stop();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// main sequence
	initial
	begin
		tick(8);
		rst_n <= 1'b1;
		rd(8'h03, 8'h01);
		rd(8'h04, 8'h00);
		rd(8'h08, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h03, 8'(i));
			#1 chk(ilim_sel, 8'(i));
		end
		wr(8'h03, 8'h81);
		charge_phase_req <= 1'b1;
		flash_active <= 1'b1;
		tx_lvl <= 1'b1;
		tick(6);
		#1 chk(transmit_mask_flag, 8'h01);
		chk(boost_low_side_switch, 8'h01);
		rd(8'h08, 8'h08);
		tick(1);
		tx_lvl <= 1'b0;
		tick(5);
		rd(8'h08, 8'h08);
		chk(transmit_mask_flag, 8'h00);
		tick(1);
		flash_active <= 1'b0;
		low_lvl <= 1'b1;
		wr(8'h04, 8'h45);
		tick(4);
		flash_start_req <= 1'b1;
		tick(1);
		flash_start_req <= 1'b0;
		flash_active <= 1'b1;
		low_lvl <= 1'b0;
		tick(5);
		#1 chk(input_low_flag, 8'h01);
		chk(low_input_threshold_sel, 8'h05);
		chk(boost_low_side_switch, 8'h01);
		chk(ilim_sel, 8'h01);
		rd(8'h08, 8'h02);
		chk(input_low_flag, 8'h00);
		rd(8'h04, 8'h45);
		tick(1);
		flash_active <= 1'b1;
		low_lvl <= 1'b1;
		tick(4);
		flash_start_req <= 1'b1;
		tick(1);
		flash_start_req <= 1'b0;
		hit_lvl <= 1'b1;
		tick(5);
		#1 chk(input_low_flag, 8'h00);
		chk(boost_low_side_switch, 8'h00);
		rd(8'h08, 8'h00);
		tick(1);
		hit_lvl <= 1'b0;
		tick(5);
		#1 chk(boost_low_side_switch, 8'h01);
		rd(8'h09, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h03, 8'h81);
		report_and_stop();
	end
endmodule : fsf_status_flags_tb
